// >>> core/cbc_bus_ctrl.sv
// Bus-control and status pin logic of the processor bus interface
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/10ps

module cbc_bus_ctrl
(
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  // Pins
  input  wire logic                 ratio_strap_i,
  input  wire logic                 abort_retry_n_i,
  input  wire logic                 transfer_ready_n_i,
  input  wire logic                 cycle_failed_n_i,
  input  wire logic                 cacheable_input_n_i,
  input  wire logic [63:0]          data_i,
  output logic                      bus_want_out_o,
  output logic [3:0]                debug_match_out_o,
  output logic                      cache_n_o,
  output logic                      cycle_start_n_o,
  output logic [31:0]               addr_o,
  output logic                      addr_oe_o,
  output logic                      write_o,
  output logic                      write_oe_o,
  // Core side
  input  wire logic                 core_req_i,
  input  wire logic [31:0]          core_addr_i,
  input  wire logic                 core_write_i,
  input  wire logic                 core_cacheable_i,
  input  wire logic [3:0]           debug_hit_i,
  input  wire logic [1:0]           perf_event_i,
  output logic                      core_ack_o,
  output logic [63:0]               core_rdata_o,
  output logic                      core_rvalid_o,
  output logic                      core_fill_o,
  output logic                      machine_check_o,
  output cbc_pkg::cbc_ratio_t       ratio_o,
  // Register port
  input  wire logic [3:0]           reg_addr_i,
  input  wire logic [31:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic [31:0]               reg_rdata_o
);
  import cbc_pkg::*;

  typedef enum logic [1:0] {CBC_IDLE, CBC_T1, CBC_T2, CBC_HOLD} cbc_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic abort_n_s;
  logic ready_n_s;
  logic failed_n_s;
  logic cache_in_n_s;

  cbc_sync2 u_sync_abort
  (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .d_i       (abort_retry_n_i),
    .q_o       (abort_n_s)
  );
  cbc_sync2 u_sync_ready
  (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .d_i       (transfer_ready_n_i),
    .q_o       (ready_n_s)
  );
  cbc_sync2 u_sync_failed
  (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .d_i       (cycle_failed_n_i),
    .q_o       (failed_n_s)
  );
  cbc_sync2 u_sync_cache
  (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .d_i       (cacheable_input_n_i),
    .q_o       (cache_in_n_s)
  );

  // Data bus is qualified by burst ready, so it is only staged, not synchronised
  logic [63:0] data_m_r;
  logic [63:0] data_s_r;
  always_ff @(posedge clock_i)
  begin
    data_m_r <= data_i;
    data_s_r <= data_m_r;
  end

  cbc_ratio_strap u_ratio
  (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .strap_i (ratio_strap_i),
    .ratio_o (ratio_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle state machine
  cbc_state_t  state_r;
  cbc_state_t  state_nxt;
  logic [31:0] cyc_addr_r;
  logic        cyc_write_r;
  logic        cyc_cache_r;
  logic [1:0]  beat_r;
  logic        retry_r;

  wire abort_w     = !abort_n_s;
  wire in_data_w   = (state_r == CBC_T2);
  wire ready_w     = in_data_w && !ready_n_s;
  wire last_beat_w = ready_w && (!cyc_cache_r || beat_r == CBC_BURST_LAST);
  wire new_cyc_w   = (state_r == CBC_IDLE) && core_req_i && !abort_w;
  wire restart_w   = (state_r == CBC_HOLD) && !abort_w && retry_r;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      CBC_IDLE: if (abort_w) state_nxt = CBC_HOLD;
                else if (new_cyc_w) state_nxt = CBC_T1;
      CBC_T1:   state_nxt = abort_w ? CBC_HOLD : CBC_T2;
      CBC_T2:   if (abort_w) state_nxt = CBC_HOLD;
                else if (last_beat_w) state_nxt = CBC_IDLE;
      CBC_HOLD: if (!abort_w) state_nxt = retry_r ? CBC_T1 : CBC_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r     <= CBC_IDLE;
      cyc_addr_r  <= 32'h0000_0000;
      cyc_write_r <= 1'b0;
      cyc_cache_r <= 1'b0;
      beat_r      <= 2'h0;
      retry_r     <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (new_cyc_w)
      begin
        cyc_addr_r  <= core_addr_i;
        cyc_write_r <= core_write_i;
        cyc_cache_r <= core_cacheable_i;
      end
      // Aborted cycle restarts from its first transfer
      if (new_cyc_w || restart_w || abort_w)
        beat_r <= 2'h0;
      else if (ready_w)
        beat_r <= beat_r + 2'h1;
      if (abort_w && state_r inside {CBC_T1, CBC_T2})
        retry_r <= 1'b1;
      else if (restart_w)
        retry_r <= 1'b0;
    end
  end

  // Floated while in hold; address and direction are the hold-floated pins
  wire drive_w = (state_r == CBC_T1) || (state_r == CBC_T2);
  assign addr_oe_o       = drive_w;
  assign write_oe_o      = drive_w;
  assign addr_o          = cyc_addr_r;
  assign write_o         = cyc_write_r;
  assign cycle_start_n_o = !(state_r == CBC_T1);
  assign cache_n_o       = !(drive_w && cyc_cache_r);
  assign bus_want_out_o  = core_req_i || retry_r || drive_w;
  assign core_ack_o      = new_cyc_w;

  ////////////////////////////////////////////////////////////////////////////
  // Read data return
  logic [63:0] rdata_r;
  logic        rvalid_r;
  logic        fill_r;
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_r  <= 64'h0000_0000_0000_0000;
      rvalid_r <= 1'b0;
      fill_r   <= 1'b0;
    end
    else
    begin
      rvalid_r <= ready_w && !cyc_write_r && !abort_w;
      if (ready_w && !cyc_write_r)
        rdata_r <= data_s_r;
      // Cache input cannot override an uncacheable read
      fill_r <= ready_w && !cyc_write_r && !abort_w && cyc_cache_r && !cache_in_n_s;
    end
  end
  assign core_rdata_o  = rdata_r;
  assign core_rvalid_o = rvalid_r;
  assign core_fill_o   = fill_r;

  ////////////////////////////////////////////////////////////////////////////
  // Machine check capture
  logic [31:0] mc_addr_r;
  logic [1:0]  mc_ctl_r;
  logic        mc_valid_r;
  logic        mc_exc_r;
  logic [1:0]  pfs_r;
  logic [3:0]  bpen_r;
  logic        mce_r;

  wire failed_w  = !failed_n_s && drive_w;
  wire wr_w      = reg_wr_i;
  wire wr_ctrl_w = wr_w && (reg_addr_i == CBC_OFS_CTRL);
  wire clr_st_w  = wr_w && (reg_addr_i == CBC_OFS_STATUS);

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mc_addr_r  <= 32'h0000_0000;
      mc_ctl_r   <= 2'h0;
      mc_valid_r <= 1'b0;
      mc_exc_r   <= 1'b0;
    end
    else
    begin
      if (failed_w)
      begin
        mc_addr_r <= cyc_addr_r;
        mc_ctl_r  <= {cyc_cache_r, cyc_write_r};
      end
      // Set wins over a software clear in the same cycle
      mc_valid_r <= failed_w || (mc_valid_r && !(clr_st_w && reg_wdata_i[CBC_ST_MCV_BIT]));
      mc_exc_r   <= (failed_w && mce_r)
                    || (mc_exc_r && !(clr_st_w && reg_wdata_i[CBC_ST_MCX_BIT]));
    end
  end
  assign machine_check_o = mc_exc_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control register and debug pins
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pfs_r  <= CBC_PFS_RST;
      bpen_r <= CBC_BPEN_RST;
      mce_r  <= 1'b0;
    end
    else if (wr_ctrl_w)
    begin
      pfs_r  <= reg_wdata_i[CBC_CTRL_PFS_LSB +: 2];
      bpen_r <= reg_wdata_i[CBC_CTRL_BPEN_LSB +: 4];
      mce_r  <= reg_wdata_i[CBC_CTRL_MCE_BIT];
    end
  end

  logic [3:0] dbg_r;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_dbg
      wire hit_w = debug_hit_i[gi] && bpen_r[gi];
      if (gi < 2)
      begin : g_shared
        always_ff @(posedge clock_i or negedge rst_n_i)
        begin
          if (!rst_n_i)
            dbg_r[gi] <= 1'b0;
          else
            dbg_r[gi] <= pfs_r[gi] ? perf_event_i[gi] : hit_w;
        end
      end
      else
      begin : g_plain
        always_ff @(posedge clock_i or negedge rst_n_i)
        begin
          if (!rst_n_i)
            dbg_r[gi] <= 1'b0;
          else
            dbg_r[gi] <= hit_w;
        end
      end
    end
  endgenerate
  assign debug_match_out_o = dbg_r;

  ////////////////////////////////////////////////////////////////////////////
  // Register read
  logic [31:0] rd_mux_w;
  logic [31:0] rdata_q_r;
  always_comb
  begin
    rd_mux_w = 32'h0000_0000;
    unique case (reg_addr_i)
      CBC_OFS_CTRL:   rd_mux_w = {24'h000000, bpen_r, 1'b0, mce_r, pfs_r};
      CBC_OFS_STATUS: rd_mux_w = {27'h0000000, retry_r, state_r == CBC_HOLD,
                                  mc_exc_r, mc_valid_r, ratio_o == CBC_RATIO_TWO_THIRDS};
      CBC_OFS_MCADDR: rd_mux_w = mc_addr_r;
      CBC_OFS_MCCTL:  rd_mux_w = {30'h00000000, mc_ctl_r};
      CBC_OFS_DBGHIT: rd_mux_w = {28'h0000000, dbg_r};
      default:        rd_mux_w = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_q_r <= 32'h0000_0000;
    else
      rdata_q_r <= reg_rd_i ? rd_mux_w : 32'h0000_0000;
  end
  assign reg_rdata_o = rdata_q_r;

endmodule : cbc_bus_ctrl

// >>> core/cbc_pkg.sv
// Package: constants and types for the bus-control pin block
package cbc_pkg;

  // Bus/core ratio encoding held after reset
  typedef enum logic {CBC_RATIO_HALF, CBC_RATIO_TWO_THIRDS} cbc_ratio_t;

  // Register offsets on the plain register port
  localparam logic [3:0] CBC_OFS_CTRL   = 4'h0;
  localparam logic [3:0] CBC_OFS_STATUS = 4'h1;
  localparam logic [3:0] CBC_OFS_MCADDR = 4'h2;
  localparam logic [3:0] CBC_OFS_MCCTL  = 4'h3;
  localparam logic [3:0] CBC_OFS_DBGHIT = 4'h4;

  // Control register fields
  localparam int CBC_CTRL_PFS_LSB = 0;   // pin_function_select[1:0]
  localparam int CBC_CTRL_MCE_BIT = 2;   // machine_check_enable of control_reg_four
  localparam int CBC_CTRL_BPEN_LSB = 4;  // breakpoint enables [7:4]

  // Status register fields
  localparam int CBC_ST_RATIO_BIT = 0;
  localparam int CBC_ST_MCV_BIT   = 1;
  localparam int CBC_ST_MCX_BIT   = 2;
  localparam int CBC_ST_HOLD_BIT  = 3;
  localparam int CBC_ST_RETRY_BIT = 4;

  // Reset values
  localparam logic [1:0] CBC_PFS_RST  = 2'h3;   // Both low pins as perf monitor
  localparam logic [3:0] CBC_BPEN_RST = 4'h0;

  // Index of the last transfer of a four-transfer cacheable cycle
  localparam logic [1:0] CBC_BURST_LAST = 2'h3;

  // Non-warm reset length
  localparam int CBC_COLD_RESET_US = 1000;
  localparam int CBC_CLK_MHZ       = 125;
  localparam int CBC_COLD_RESET_CYC = CBC_COLD_RESET_US * CBC_CLK_MHZ;

endpackage : cbc_pkg

// >>> core/cbc_sync2.sv
// Two-flop synchroniser for one pin level
`timescale 1ns/10ps
module cbc_sync2
(
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;
  logic sync_r;

  // Resets to the idle high level shared by all active-low pins it serves
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end
    else
    begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule : cbc_sync2

// >>> core/cbc_ratio_strap.sv
// Captures the bus ratio strap while reset is held
`timescale 1ns/10ps
module cbc_ratio_strap
(
  input  wire logic          clock_i,
  input  wire logic          rst_n_i,
  input  wire logic          strap_i,
  output cbc_pkg::cbc_ratio_t ratio_o
);
  import cbc_pkg::*;

  logic       strap_s;
  logic       strap_meta_r;
  logic       strap_sync_r;
  cbc_ratio_t ratio_r;

  // Synchroniser kept free of reset so it keeps sampling during reset
  always_ff @(posedge clock_i)
  begin
    strap_meta_r <= strap_i;
    strap_sync_r <= strap_meta_r;
  end

  assign strap_s = strap_sync_r;

  // Clocked capture while reset is low; held from release onward
  // Floating strap is pulled high at the pad, so it lands on 2/3
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      ratio_r <= strap_s ? CBC_RATIO_TWO_THIRDS : CBC_RATIO_HALF;
  end

  assign ratio_o = ratio_r;

endmodule : cbc_ratio_strap

// >>> verif/cbc_chipset_model.sv
// Chipset model answering processor bus cycles with burst ready and read data
`timescale 1ns/10ps
module cbc_chipset_model
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        slow_i,
  input  wire logic        start_n_i,
  input  wire logic        addr_oe_i,
  input  wire logic [31:0] addr_i,
  output logic             ready_n_o,
  output logic [63:0]      data_o
);
  logic [2:0] wait_r;
  logic [3:0] beat_r;
  wire        in_data = addr_oe_i && start_n_i;
  wire        fire    = in_data && (wait_r == (slow_i ? 3'h6 : 3'h0));
  ////////////////////////////////////////////////////////////////////////////////
  // Ready only while the cycle drives its pins; low means ready
  // Idle data bus toggles so a stale beat never looks valid
  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      wait_r    <= 3'h0;
      beat_r    <= 4'h0;
      ready_n_o <= 1'b1;
      data_o    <= 64'h0;
    end
    else
    begin
      wait_r    <= (!start_n_i || fire) ? 3'h0 : wait_r + {2'h0, in_data};
      beat_r    <= !start_n_i ? 4'h0 : beat_r + {3'h0, fire};
      ready_n_o <= !fire;
      data_o    <= fire ? {addr_i, 28'h0, beat_r} : ~data_o;
    end
endmodule : cbc_chipset_model

// >>> verif/cbc_bus_ctrl_checker.sv
// Concurrent checks on the bus-control pin block ports
`timescale 1ns/10ps
module cbc_bus_ctrl_checker
(
  input wire logic                clock_i,
  input wire logic                rst_n_i,
  input wire logic                abort_retry_n_i,
  input wire logic                transfer_ready_n_i,
  input wire logic [63:0]         data_i,
  input wire logic                bus_want_out_o,
  input wire logic [3:0]          debug_match_out_o,
  input wire logic                cache_n_o,
  input wire logic                cycle_start_n_o,
  input wire logic                addr_oe_o,
  input wire logic                write_oe_o,
  input wire logic                core_req_i,
  input wire logic [3:0]          debug_hit_i,
  input wire logic [63:0]         core_rdata_o,
  input wire logic                core_rvalid_o,
  input wire logic                core_fill_o,
  input wire cbc_pkg::cbc_ratio_t ratio_o,
  input wire logic                reg_rd_i,
  input wire logic [31:0]         reg_rdata_o
);
  import cbc_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  sequence abort_retry_n_held_s;
    !abort_retry_n_i [*4];
  endsequence
  sequence beat_taken_s;
    !transfer_ready_n_i ##3 core_rvalid_o;
  endsequence
  hold_float_a: assert property (abort_retry_n_held_s |-> !addr_oe_o && !write_oe_o)
    else $error("pins driven during backoff");
  beat_data_a: assert property (core_rvalid_o |-> $past(!transfer_ready_n_i, 3)
    && core_rdata_o == $past(data_i, 3)) else $error("read beat without ready");
  beat_seen_a: assert property (beat_taken_s |-> core_rdata_o == $past(data_i, 3))
    else $error("read data not from ready clock");
  want_drive_a: assert property (core_req_i || addr_oe_o |-> bus_want_out_o)
    else $error("bus want low with request");
  start_drive_a: assert property (!cycle_start_n_o |-> addr_oe_o && bus_want_out_o)
    else $error("cycle start without driven pins");
  cache_drive_a: assert property (!cache_n_o |-> addr_oe_o)
    else $error("cache pin active outside a cycle");
  fill_beat_a: assert property (core_fill_o |-> core_rvalid_o)
    else $error("cache fill without read beat");
  hit_source_a: assert property ((debug_match_out_o[3:2] & ~$past(debug_hit_i[3:2])) == 2'h0)
    else $error("breakpoint output without hit");
  ratio_kept_a: assert property ($past(rst_n_i, 3) |-> $stable(ratio_o))
    else $error("ratio changed outside reset");
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside answer cycle");
endmodule : cbc_bus_ctrl_checker

bind cbc_bus_ctrl cbc_bus_ctrl_checker chk_i (.*);

// >>> verif/cbc_bus_ctrl_bench.sv
// Self-checking bench for the bus-control pin block
`timescale 1ns/10ps
module cbc_bus_ctrl_bench;
  import cbc_pkg::*;
  logic clock_i = 0, rst_n_i = 0, ratio_strap_i = 1, abort_retry_n_i = 1;
  logic cycle_failed_n_i = 1, cacheable_input_n_i = 1, core_req_i = 0, slow = 0;
  logic core_write_i = 0, core_cacheable_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic transfer_ready_n_i, bus_want_out_o, cache_n_o, cycle_start_n_o, addr_oe_o;
  logic write_o, write_oe_o, core_ack_o, core_rvalid_o, core_fill_o, machine_check_o;
  logic [3:0]  reg_addr_i = 4'h0, debug_hit_i = 4'h0, debug_match_out_o;
  logic [1:0]  perf_event_i = 2'h0;
  logic [31:0] reg_wdata_i = 32'h0, core_addr_i = 32'h1000_0000, addr_o, reg_rdata_o, v;
  logic [63:0] data_i, core_rdata_o;
  cbc_ratio_t  ratio_o;
  int          bad_count = 0;
  int          samples_checked = 0;
  always #4 clock_i = ~clock_i;
  cbc_bus_ctrl dut (.*);
  cbc_chipset_model model (.clock_i(clock_i), .rst_n_i(rst_n_i), .slow_i(slow),
    .start_n_i(cycle_start_n_o), .addr_oe_i(addr_oe_o), .addr_i(addr_o),
    .ready_n_o(transfer_ready_n_i), .data_o(data_i));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk(string n, logic [63:0] s, logic [63:0] e);
    samples_checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd
  // Strap held steady across the whole reset
  task automatic doreset(logic s);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    ratio_strap_i <= s;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(negedge clock_i);
  endtask : doreset
  // One read cycle; bo backs off mid-cycle, bf flags bus check in the data phase
  task automatic go(logic c, logic k, logic bo, logic bf);
    int n, f, s;
    logic [63:0] d;
    logic [31:0] a;
    n = 0;
    f = 0;
    s = 0;
    d = 64'h0;
    a = core_addr_i + 32'h40;
    @(posedge clock_i);
    core_req_i <= 1'b1;
    core_addr_i <= a;
    core_cacheable_i <= c;
    cacheable_input_n_i <= k;
    slow <= bo | bf;
    @(negedge clock_i);
    for (int i = 0; i < 20 && core_ack_o !== 1'b1; i++) @(negedge clock_i);
    @(posedge clock_i);
    core_req_i <= 1'b0;
    @(negedge clock_i);
    s += int'(cycle_start_n_o === 1'b0);
    for (int i = 0; i < 80; i++)
    begin
      @(posedge clock_i);
      abort_retry_n_i <= !(bo && i >= 1 && i < 9);
      cycle_failed_n_i <= !(bf && i == 3);
      @(negedge clock_i);
      if (core_rvalid_o === 1'b1 && n == 0) d = core_rdata_o;
      n += int'(core_rvalid_o === 1'b1);
      f += int'(core_fill_o === 1'b1);
      s += int'(cycle_start_n_o === 1'b0);
      if (bo && i == 6) chk("floated", {addr_oe_o, write_oe_o}, 64'h0);
      if (i == 0) chk("pins", 64'({bus_want_out_o, write_o, write_oe_o, cache_n_o}),
        64'({1'b1, 1'b0, 1'b1, !c}));
    end
    chk("beats", 64'(n), c ? 64'h4 : 64'h1);
    chk("fill", 64'(f), (c && !k) ? 64'h4 : 64'h0);
    chk("starts", 64'(s), bo ? 64'h2 : 64'h1);
    chk("data", d, {a, 32'h0});
  endtask : go
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    doreset(1'b0);
    chk("ratio", 64'(ratio_o), 64'(CBC_RATIO_HALF));
    doreset(1'b1);
    ratio_strap_i <= 1'b0;
    chk("ratio", 64'(ratio_o), 64'(CBC_RATIO_TWO_THIRDS));
    rd(CBC_OFS_STATUS);
    chk("st ratio", 64'(v[CBC_ST_RATIO_BIT]), 64'h1);
    rd(CBC_OFS_CTRL);
    chk("ctrl", 64'({v[7:4], v[1:0]}), 64'({CBC_BPEN_RST, CBC_PFS_RST}));
    perf_event_i <= 2'h2;
    debug_hit_i <= 4'hF;
    repeat (3) @(posedge clock_i);
    chk("perf", 64'(debug_match_out_o), 64'h2);
    wr(CBC_OFS_CTRL, 32'h0000_00F0);
    repeat (3) @(posedge clock_i);
    chk("bp", 64'(debug_match_out_o), 64'hF);
    rd(4'hF);
    chk("unmapped", 64'(v), 64'h0);
    go(1'b0, 1'b1, 1'b0, 1'b0);
    go(1'b1, 1'b0, 1'b0, 1'b0);
    go(1'b0, 1'b0, 1'b0, 1'b0);
    go(1'b1, 1'b1, 1'b0, 1'b0);
    go(1'b0, 1'b1, 1'b1, 1'b0);
    for (int m = 0; m < 2; m++)
    begin
      go(1'b0, 1'b1, 1'b0, 1'b1);
      rd(CBC_OFS_STATUS);
      chk("mc st", 64'(v[2:1]), m ? 64'h3 : 64'h1);
      chk("mc exc", 64'(machine_check_o), 64'(m));
      rd(CBC_OFS_MCADDR);
      chk("mc addr", 64'(v), 64'(core_addr_i));
      wr(CBC_OFS_STATUS, 32'h0000_0006);
      wr(CBC_OFS_CTRL, 32'h0000_0004);
    end
    chk("ratio kept", 64'(ratio_o), 64'(CBC_RATIO_TWO_THIRDS));
    summarize();
  end
  initial
  begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule : cbc_bus_ctrl_bench
